/* File: hdl/psg_top.sv */
// four independent pwm units with sequence fetch and an apb register slave
//
// Functional notes
// [R1] one up or up-down counter, four pins
// [R2] counter clock 16 MHz prescaled by powers of two
// [R3] per channel polarity and duty value
// [R4] edge aligned up, center aligned up-down
// [R5] two memory sequences selectable as source
// [R6] own fetch master, glitch-free update
// [R7] new duty, polarity, top each period
// [R8] sequences repeat and chain into loop
// [R9] up to 16 MHz, duty 0 to 100%
// [R10] duty resolution equals counter steps per period
// [R11] four independent units, each own fetcher
// [R12] top sets period; up-down doubles it
// [R13] high while counter below duty, optionally inverted
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/100ps
module psg_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [psg_pkg::UNITS-1:0] memReq,
  output logic [psg_pkg::UNITS*32-1:0] memAddr,
  input wire logic [psg_pkg::UNITS-1:0] memAck,
  input wire logic [psg_pkg::UNITS*32-1:0] memRdata,
  output logic [psg_pkg::UNITS*psg_pkg::CHANS-1:0] pwmOut
);
  localparam int U = psg_pkg::UNITS;
  localparam int C = psg_pkg::CHANS;
  localparam int DW = psg_pkg::DUTY_W;

  // ******************************************
  // 16 MHz base enable from the 20 MHz core clock
  // ******************************************
  logic [5:0] acc_r, acc_nxt;
  logic base_r, base_nxt;
  // fractional divider: four pulses in five cycles, jitter of one core cycle
  // [R2] base rate
  always_comb begin
    if (acc_r + psg_pkg::ACC_STEP >= psg_pkg::ACC_WRAP) begin
      acc_nxt = acc_r + psg_pkg::ACC_STEP - psg_pkg::ACC_WRAP;
      base_nxt = 1'b1;
    end else begin
      acc_nxt = acc_r + psg_pkg::ACC_STEP;
      base_nxt = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      acc_r <= 6'h00;
      base_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      base_r <= base_nxt;
    end
  end

  // ******************************************
  // apb slave, one wait state
  // ******************************************
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [31:0] unitRd [U];
  logic [1:0] selUnit;
  logic [5:0] selOff;
  logic offOk;
  logic wrEn;
  assign selUnit = paddr[psg_pkg::UNIT_LSB+:2];
  assign selOff = paddr[5:0];
  assign offOk = (paddr < psg_pkg::MAP_END) && (selOff <= psg_pkg::OFF_STATUS)
    && (selOff[1:0] == 2'b00);
  // write lands on the edge that sees pready high
  assign wrEn = psel && penable && pwrite && pready_r && offOk;
  // answer registered so every bus output leaves a flop
  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = psel && penable && !pready_r && !offOk;
    prdata_nxt = 32'h0000_0000;
    if (psel && penable && !pready_r && !pwrite && offOk) begin
      prdata_nxt = unitRd[selUnit];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // ******************************************
  // the four generator units
  // ******************************************
  // [R11] independent copies
  for (genvar u = 0; u < U; u++) begin : g_unit
    logic hit;
    logic [psg_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [DW-1:0] top_r, top_nxt;
    logic [31:0] ptr0_r, ptr0_nxt, ptr1_r, ptr1_nxt;
    logic [15:0] cnt0_r, cnt0_nxt, cnt1_r, cnt1_nxt;
    logic [7:0] rep_r, rep_nxt;
    logic startReq;
    assign hit = wrEn && (selUnit == 2'(u));
    assign startReq = hit && (selOff == psg_pkg::OFF_CTRL) && pwdata[psg_pkg::CTRL_START];

    // configuration registers written by software
    always_comb begin
      ctrl_nxt = ctrl_r;
      top_nxt = top_r;
      ptr0_nxt = ptr0_r;
      ptr1_nxt = ptr1_r;
      cnt0_nxt = cnt0_r;
      cnt1_nxt = cnt1_r;
      rep_nxt = rep_r;
      if (hit) begin
        case (selOff)
          psg_pkg::OFF_CTRL: ctrl_nxt = pwdata[psg_pkg::CTRL_W-1:0];
          psg_pkg::OFF_TOP: top_nxt = pwdata[DW-1:0];
          psg_pkg::OFF_SEQ0_PTR: ptr0_nxt = {pwdata[31:2], 2'b00};
          psg_pkg::OFF_SEQ0_CNT: cnt0_nxt = pwdata[15:0];
          psg_pkg::OFF_SEQ1_PTR: ptr1_nxt = {pwdata[31:2], 2'b00};
          psg_pkg::OFF_SEQ1_CNT: cnt1_nxt = pwdata[15:0];
          psg_pkg::OFF_REPEAT: rep_nxt = pwdata[7:0];
          default: ctrl_nxt = ctrl_r;
        endcase
      end
    end
    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        ctrl_r <= psg_pkg::CTRL_RST;
        top_r <= psg_pkg::TOP_RST;
        ptr0_r <= 32'h0000_0000;
        ptr1_r <= 32'h0000_0000;
        cnt0_r <= psg_pkg::CNT_RST;
        cnt1_r <= psg_pkg::CNT_RST;
        rep_r <= psg_pkg::REP_RST;
      end else begin
        ctrl_r <= ctrl_nxt;
        top_r <= top_nxt;
        ptr0_r <= ptr0_nxt;
        ptr1_r <= ptr1_nxt;
        cnt0_r <= cnt0_nxt;
        cnt1_r <= cnt1_nxt;
        rep_r <= rep_nxt;
      end
    end

    // engine and counter state
    psg_pkg::psg_state_t st_r, st_nxt;
    logic run_r, run_nxt, seq_r, seq_nxt, bufOk_r, bufOk_nxt, req_r, req_nxt;
    logic down_r, down_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [15:0] left_r, left_nxt;
    logic [7:0] repLeft_r, repLeft_nxt;
    logic [63:0] buf_r, buf_nxt, act_r, act_nxt;
    logic [DW-1:0] cnt_r, cnt_nxt, topAct_r, topAct_nxt;
    logic [6:0] div_r, div_nxt;
    logic [C-1:0] out_r, out_nxt;
    logic tick, edge_w, en;
    logic [6:0] mask;
    logic [31:0] rd;
    assign en = ctrl_r[psg_pkg::CTRL_EN];
    assign mask = 7'((8'h01 << ctrl_r[psg_pkg::CTRL_PS_LSB+:3]) - 8'h01);
    // [R2] divide by 1 to 128
    assign tick = base_r && ((div_r & mask) == mask);
    assign rd = memRdata[u*32+:32];

    always_comb begin
      st_nxt = st_r;
      run_nxt = run_r;
      seq_nxt = seq_r;
      bufOk_nxt = bufOk_r;
      req_nxt = req_r;
      down_nxt = down_r;
      addr_nxt = addr_r;
      left_nxt = left_r;
      repLeft_nxt = repLeft_r;
      buf_nxt = buf_r;
      act_nxt = act_r;
      cnt_nxt = cnt_r;
      topAct_nxt = topAct_r;
      div_nxt = base_r ? div_r + 7'h01 : div_r;
      edge_w = 1'b0;
      out_nxt = '0;
      // [R5] chosen sequence becomes the source
      if (startReq) begin
        run_nxt = 1'b1;
        seq_nxt = pwdata[psg_pkg::CTRL_SEQ];
        addr_nxt = pwdata[psg_pkg::CTRL_SEQ] ? ptr1_r : ptr0_r;
        left_nxt = pwdata[psg_pkg::CTRL_SEQ] ? cnt1_r : cnt0_r;
        repLeft_nxt = rep_r;
        bufOk_nxt = 1'b0;
        st_nxt = psg_pkg::ST_IDLE;
        req_nxt = 1'b0;
      end else begin
        // [R6] autonomous fetch of two words per entry
        case (st_r)
          psg_pkg::ST_IDLE: begin
            if (run_r && !bufOk_r && en) begin
              st_nxt = psg_pkg::ST_FETCH_LO;
              req_nxt = 1'b1;
            end
          end
          psg_pkg::ST_FETCH_LO: begin
            if (memAck[u]) begin
              buf_nxt[31:0] = rd;
              addr_nxt = addr_r + 32'h0000_0004;
              st_nxt = psg_pkg::ST_FETCH_HI;
            end
          end
          psg_pkg::ST_FETCH_HI: begin
            if (memAck[u]) begin
              buf_nxt[63:32] = rd;
              bufOk_nxt = 1'b1;
              req_nxt = 1'b0;
              st_nxt = psg_pkg::ST_IDLE;
              addr_nxt = addr_r + 32'h0000_0004;
              left_nxt = left_r - 16'h0001;
              // [R8] repeat, chain or stop at end of sequence
              if (left_r <= 16'h0001) begin
                if (repLeft_r != 8'h00) begin
                  repLeft_nxt = repLeft_r - 8'h01;
                  addr_nxt = seq_r ? ptr1_r : ptr0_r;
                  left_nxt = seq_r ? cnt1_r : cnt0_r;
                end else if (ctrl_r[psg_pkg::CTRL_LOOP]) begin
                  seq_nxt = !seq_r;
                  repLeft_nxt = rep_r;
                  addr_nxt = seq_r ? ptr0_r : ptr1_r;
                  left_nxt = seq_r ? cnt0_r : cnt1_r;
                end else begin
                  run_nxt = 1'b0;
                end
              end
            end
          end
          default: st_nxt = psg_pkg::ST_IDLE;
        endcase
      end
      // disabling aborts any fetch and parks the counter
      if (!en) begin
        run_nxt = startReq;
        req_nxt = 1'b0;
        st_nxt = psg_pkg::ST_IDLE;
        cnt_nxt = '0;
        down_nxt = 1'b0;
      end else if (tick) begin
        // [R12] period from top value
        if (!ctrl_r[psg_pkg::CTRL_UPDN]) begin
          // [R4] edge aligned
          if (cnt_r >= topAct_r) begin
            cnt_nxt = '0;
            edge_w = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 15'h0001;
          end
        end else if (!down_r) begin
          // [R4] center aligned, reverses at top
          if (topAct_r == '0) begin
            edge_w = 1'b1;
          end else if (cnt_r >= topAct_r) begin
            down_nxt = 1'b1;
            cnt_nxt = cnt_r - 15'h0001;
          end else begin
            cnt_nxt = cnt_r + 15'h0001;
          end
        end else begin
          cnt_nxt = cnt_r - 15'h0001;
          if (cnt_r <= 15'h0001) begin
            down_nxt = 1'b0;
            edge_w = 1'b1;
          end
        end
      end
      // [R7] new values only at the period boundary
      if (edge_w) begin
        topAct_nxt = top_r;
        if (bufOk_r && !startReq) begin
          act_nxt = buf_r;
          bufOk_nxt = 1'b0;
        end
      end
      // [R3] per channel polarity and duty
      for (int c = 0; c < C; c++) begin
        // [R13] compare then invert; [R9] duty 0 is low, above top is high
        // [R10] levels limited by steps per period
        out_nxt[c] = en && ((cnt_r < act_r[c*16+:DW]) ^ act_r[c*16+psg_pkg::ENT_POL]);
      end
    end
    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        st_r <= psg_pkg::ST_IDLE;
        run_r <= 1'b0;
        seq_r <= 1'b0;
        bufOk_r <= 1'b0;
        req_r <= 1'b0;
        down_r <= 1'b0;
        addr_r <= 32'h0000_0000;
        left_r <= 16'h0000;
        repLeft_r <= 8'h00;
        buf_r <= 64'h0000_0000_0000_0000;
        act_r <= 64'h0000_0000_0000_0000;
        cnt_r <= '0;
        topAct_r <= psg_pkg::TOP_RST;
        div_r <= 7'h00;
        out_r <= '0;
      end else begin
        st_r <= st_nxt;
        run_r <= run_nxt;
        seq_r <= seq_nxt;
        bufOk_r <= bufOk_nxt;
        req_r <= req_nxt;
        down_r <= down_nxt;
        addr_r <= addr_nxt;
        left_r <= left_nxt;
        repLeft_r <= repLeft_nxt;
        buf_r <= buf_nxt;
        act_r <= act_nxt;
        cnt_r <= cnt_nxt;
        topAct_r <= topAct_nxt;
        div_r <= div_nxt;
        out_r <= out_nxt;
      end
    end

    // read view of this unit
    always_comb begin
      case (selOff)
        psg_pkg::OFF_CTRL: unitRd[u] = {25'h0, ctrl_r};
        psg_pkg::OFF_TOP: unitRd[u] = {17'h0, top_r};
        psg_pkg::OFF_SEQ0_PTR: unitRd[u] = ptr0_r;
        psg_pkg::OFF_SEQ0_CNT: unitRd[u] = {16'h0, cnt0_r};
        psg_pkg::OFF_SEQ1_PTR: unitRd[u] = ptr1_r;
        psg_pkg::OFF_SEQ1_CNT: unitRd[u] = {16'h0, cnt1_r};
        psg_pkg::OFF_REPEAT: unitRd[u] = {24'h0, rep_r};
        psg_pkg::OFF_STATUS: unitRd[u] = {1'b0, cnt_r, 13'h0, bufOk_r, seq_r, run_r};
        default: unitRd[u] = 32'h0000_0000;
      endcase
    end
    // [R1] four pins per unit
    assign pwmOut[u*C+:C] = out_r;
    assign memReq[u] = req_r;
    assign memAddr[u*32+:32] = addr_r;
  end
endmodule // psg_top

/* File: hdl/psg_pkg.sv */
// constants shared by the four-unit pwm sequence generator
package psg_pkg;
  // ******************************************
  // clocking
  // ******************************************
  localparam int CORE_HZ = 20_000_000;
  localparam int BASE_HZ = 16_000_000;
  localparam logic [5:0] ACC_STEP = 6'(BASE_HZ / 1_000_000);
  localparam logic [5:0] ACC_WRAP = 6'(CORE_HZ / 1_000_000);
  // ******************************************
  // unit and bus geometry
  // ******************************************
  localparam int UNITS = 4;
  localparam int CHANS = 4;
  localparam int UNIT_LSB = 6;
  localparam logic [11:0] MAP_END = 12'h0100;
  // ******************************************
  // register byte offsets inside one unit
  // ******************************************
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_TOP = 6'h04;
  localparam logic [5:0] OFF_SEQ0_PTR = 6'h08;
  localparam logic [5:0] OFF_SEQ0_CNT = 6'h0C;
  localparam logic [5:0] OFF_SEQ1_PTR = 6'h10;
  localparam logic [5:0] OFF_SEQ1_CNT = 6'h14;
  localparam logic [5:0] OFF_REPEAT = 6'h18;
  localparam logic [5:0] OFF_STATUS = 6'h1C;
  // ******************************************
  // control fields
  // ******************************************
  localparam int CTRL_EN = 0;
  localparam int CTRL_UPDN = 1;
  localparam int CTRL_PS_LSB = 2;
  localparam int CTRL_LOOP = 5;
  localparam int CTRL_SEQ = 6;
  localparam int CTRL_START = 7;
  localparam int CTRL_W = 7;
  // ******************************************
  // sequence entry fields, 16 bits per channel
  // ******************************************
  localparam int ENT_POL = 15;
  localparam int DUTY_W = 15;
  // ******************************************
  // reset values
  // ******************************************
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [14:0] TOP_RST = 15'h03E7;
  localparam logic [15:0] CNT_RST = 16'h0001;
  localparam logic [7:0] REP_RST = 8'h00;
  typedef enum {ST_IDLE, ST_FETCH_LO, ST_FETCH_HI} psg_state_t;
endpackage

/* File: verif/psg_asserts.sv */
// port checks for the pwm sequence generator
`timescale 1ns/100ps
module psg_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [psg_pkg::UNITS-1:0] memReq,
  input wire logic [psg_pkg::UNITS*32-1:0] memAddr,
  input wire logic [psg_pkg::UNITS-1:0] memAck,
  input wire logic [psg_pkg::UNITS*psg_pkg::CHANS-1:0] pwmOut
);
  // ****
  // register bus
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // access phase not yet answered
  sequence accWait;
    psel && penable && !pready;
  endsequence
  AST_RDY_LAT: assert property (accWait |=> pready)
    else $error("ready late");
  AST_RDY_IN: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_BAD_ADDR: assert property (accWait ##0 (paddr >= 12'h100 || paddr[1:0] != 2'b00)
    |=> pslverr) else $error("bad address accepted");
  AST_RDATA_ZERO: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  // ****
  // fetch and outputs
  // ****
  AST_RST_OUT: assert property ($rose(nrst) |-> pwmOut == '0 && memReq == '0)
    else $error("outputs live after reset");
  // aborts follow a register write, so those cycles are excluded
  AST_REQ_HOLD: assert property (memReq[0] && !memAck[0] && !psel && !$past(psel)
    |=> memReq[0] && $stable(memAddr[31:0])) else $error("request dropped");
  AST_ACK_ADV: assert property (memReq[0] && memAck[0] && !psel && !$past(psel)
    |=> !memReq[0] || memAddr[31:0] == $past(memAddr[31:0]) + 32'd4)
    else $error("address not advanced");
endmodule // psg_chk
bind psg_top psg_chk chk (.core_clk, .nrst, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .memReq, .memAddr, .memAck, .pwmOut);

/* File: verif/psg_mem_model.sv */
// memory holding the duty sequences, answering each unit's fetch
`timescale 1ns/100ps
module psg_mem_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic [psg_pkg::UNITS-1:0] memReq,
  input wire logic [psg_pkg::UNITS*32-1:0] memAddr,
  output logic [psg_pkg::UNITS-1:0] memAck,
  output logic [psg_pkg::UNITS*32-1:0] memRdata
);
  logic [1:0] waitCnt_r [psg_pkg::UNITS];
  logic [31:0] word;
  always_ff @(posedge core_clk) begin
    for (int u = 0; u < psg_pkg::UNITS; u++) begin
      memAck[u] <= 1'b0;
      // stale data flips so nothing reads it as valid
      memRdata[u*32+:32] <= nrst ? ~memRdata[u*32+:32] : 32'h0000_0000;
      word = memAddr[u*32+2] ? 32'hFFFF_8000 : 32'h7FFF_0000;
      if (memAddr[u*32+8])
        word = word ^ 32'h7FFF_7FFF;
      if (!nrst || !memReq[u] || memAck[u]) begin
        waitCnt_r[u] <= slow ? 2'd3 : 2'd0;
      end else if (waitCnt_r[u] != 2'd0) begin
        waitCnt_r[u] <= waitCnt_r[u] - 2'd1;
      end else begin
        memAck[u] <= 1'b1;
        memRdata[u*32+:32] <= word;
      end
    end
  end
endmodule // psg_mem_model

/* File: verif/tb.sv */
// self-checking bench for the pwm sequence generator
`timescale 1ns/100ps
module tb;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] memReq, memAck;
  logic [127:0] memAddr, memRdata;
  logic [15:0] pwmOut;
  int n_fail = 0;
  int samples_checked = 0;
  psg_top DUT (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
    .memRdata(memRdata), .pwmOut(pwmOut));
  psg_mem_model mem (.core_clk(core_clk), .nrst(nrst), .slow(slow), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata));
  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // one apb transfer, then an idle cycle so psel is never set twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check(w ? 32'h0000_0000 : prdata, e);
    check({31'h0, pslverr}, {31'h0, er});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // first boundary after start still uses the reset top, about 1250 cycles away
  task automatic waitPwm(input logic [15:0] e);
    int n;
    n = 0;
    while (pwmOut !== e && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    check({16'h0000, pwmOut}, {16'h0000, e});
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    summarize();
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    slow = 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    apb(0, 12'h040, 0, {25'h0, psg_pkg::CTRL_RST}, 0);
    apb(0, 12'h044, 0, {17'h0, psg_pkg::TOP_RST}, 0);
    apb(0, 12'h04C, 0, {16'h0, psg_pkg::CNT_RST}, 0);
    apb(0, 12'h058, 0, {24'h0, psg_pkg::REP_RST}, 0);
    apb(0, 12'h060, 0, 0, 1);
    apb(1, 12'h100, 32'h0000_0001, 0, 1);
    apb(0, 12'h042, 0, 0, 1);
    // all units: top 3, sequences at 0 and 0x100, up count, start
    for (int u = 0; u < 4; u++) begin
      apb(1, 12'(u * 64 + 4), 32'h0000_0003, 0, 0);
      apb(1, 12'(u * 64 + 8), 32'h0000_0000, 0, 0);
      apb(1, 12'(u * 64 + 16), 32'h0000_0100, 0, 0);
      apb(1, 12'(u * 64), 32'h0000_0081, 0, 0);
    end
    apb(0, 12'h0C4, 0, 32'h0000_0003, 0);
    waitPwm(16'h6666);
    repeat (12) @(posedge core_clk);
    check({16'h0000, pwmOut}, 32'h0000_6666);
    slow <= 1'b1;
    apb(1, 12'h000, 32'h0000_00CF, 0, 0);
    waitPwm(16'h6669);
    apb(1, 12'h000, 32'h0000_00A1, 0, 0);
    waitPwm(16'h6666);
    waitPwm(16'h6669);
    waitPwm(16'h6666);
    apb(1, 12'h000, 32'h0000_0000, 0, 0);
    waitPwm(16'h6660);
    nrst <= 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check({16'h0000, pwmOut}, 32'h0000_0000);
    summarize();
  end
endmodule // tb
